// ==== design/ces_sequencer.sv ====
// Exception detection and entry sequencing for the processor core.
`timescale 1ns/1ns
`include "ces_defs.svh"
module ces_sequencer #(
  parameter logic [31:0] PERIPH_BASE = `CES_PERIPH_BASE,
  parameter logic [31:0] PERIPH_MASK = `CES_PERIPH_MASK,
  parameter logic [31:0] PER8_BASE   = `CES_PER8_BASE,
  parameter logic [31:0] PER8_MASK   = `CES_PER8_MASK,
  parameter logic [31:0] EXT_BASE    = `CES_EXT_BASE,
  parameter logic [31:0] EXT_MASK    = `CES_EXT_MASK,
  parameter int          N_EXT       = 8
) (
  input  wire logic              clk_i,         // Core clock, 20 MHz.
  input  wire logic              rst_i,         // Asynchronous reset, active high.
  input  wire logic              single_chip_i, // Single chip mode.
  input  wire ces_pkg::ces_acc_s cpu_acc_i,     // CPU bus access.
  input  wire ces_pkg::ces_acc_s dma_acc_i,     // DMA or transfer controller access.
  output logic                   cpu_abort_o,   // Terminate CPU bus cycle.
  output logic                   dma_abort_o,   // Terminate DMA bus cycle.
  input  wire ces_pkg::ces_irq_s irq_i,         // Interrupt requests.
  output logic                   int_ack_o,     // Interrupt accepted, one cycle.
  output logic [7:0]             int_vec_o,     // Accepted vector number.
  input  wire logic              insn_done_i,   // Current instruction completes.
  input  wire logic              trap_i,        // Trap instruction executes.
  input  wire logic [7:0]        trap_vec_i,    // Trap vector number.
  input  wire logic              undef_i,       // Undefined code decoded.
  input  wire logic              in_slot_i,     // Decoded instruction is in a slot.
  input  wire logic              pc_write_i,    // Decoded instruction rewrites pc.
  input  wire logic [31:0]       cur_pc_i,      // Address of decoded instruction.
  input  wire logic [31:0]       next_pc_i,     // Address of next instruction.
  input  wire logic [31:0]       br_target_i,   // Target of preceding delayed branch.
  input  wire logic [31:0]       status_register_i, // Current status register.
  input  wire logic [31:0]       sp_i,          // Current stack pointer.
  input  wire logic [31:0]       vector_base_i, // Vector base.
  output ces_pkg::ces_mem_s      mem_o,         // Stack write or vector read.
  input  wire logic              mem_ack_i,     // Memory cycle done.
  input  wire logic [31:0]       mem_rdata_i,   // Read data for vector fetch.
  output logic                   busy_o,        // Entry sequence in progress.
  output logic                   load_o,        // Load new pc, sp, status; one cycle.
  output logic [31:0]            program_counter_o, // New program counter.
  output logic [31:0]            sp_o,          // New stack pointer.
  output logic [31:0]            status_register_o  // New status register.
);
  import ces_pkg::*;

  ces_state_e  state_q, state_d;
  ces_mem_s    mem_q, mem_d;
  logic [31:0] sp_q, sp_d;
  logic [31:0] pc_save_q, pc_save_d;
  logic [31:0] sr_new_q, sr_new_d;
  logic [31:0] pc_new_q, pc_new_d;
  logic [7:0]  vec_q, vec_d;
  logic [1:0]  aerr_q, aerr_d;
  logic        load_q, load_d;
  logic        ack_q, ack_d;
  logic        cpu_err;
  logic        dma_err;
  logic [3:0]  mask;
  logic [4:0]  best_lvl;
  logic [7:0]  best_vec;
  logic        best_nmi;
  logic        best_any;
  logic        int_take;
  logic        slot_ill;

  // Both masters share the same checking rules.
  ces_addr_check #(
    .PERIPH_BASE (PERIPH_BASE),
    .PERIPH_MASK (PERIPH_MASK),
    .PER8_BASE   (PER8_BASE),
    .PER8_MASK   (PER8_MASK),
    .EXT_BASE    (EXT_BASE),
    .EXT_MASK    (EXT_MASK)
  ) u_cpu_chk (
    .acc_i         (cpu_acc_i),
    .single_chip_i (single_chip_i),
    .err_o         (cpu_err)
  );

  ces_addr_check #(
    .PERIPH_BASE (PERIPH_BASE),
    .PERIPH_MASK (PERIPH_MASK),
    .PER8_BASE   (PER8_BASE),
    .PER8_MASK   (PER8_MASK),
    .EXT_BASE    (EXT_BASE),
    .EXT_MASK    (EXT_MASK)
  ) u_dma_chk (
    .acc_i         (dma_acc_i),
    .single_chip_i (single_chip_i),
    .err_o         (dma_err)
  );

  // The faulting cycle ends at once; the exception itself waits.
  assign cpu_abort_o = cpu_err;
  assign dma_abort_o = dma_err;

  assign mask     = status_register_i[`CES_SR_MASK_LSB +: 4];
  assign slot_ill = in_slot_i && (undef_i || pc_write_i);

  // Priority resolve: fixed sources first, ties go to the earlier source.
  // Four-bit level inputs cannot express 16, so only the pin reaches it.
  always_comb begin
    best_lvl = 5'h00;
    best_vec = 8'h00;
    best_nmi = 1'b0;
    best_any = 1'b0;
    if (irq_i.nmi) begin
      best_lvl = `CES_LVL_NMI;
      best_vec = `CES_VEC_NMI;
      best_nmi = 1'b1;
      best_any = 1'b1;
    end else if (irq_i.ubreak) begin
      best_lvl = `CES_LVL_UBREAK;
      best_vec = `CES_VEC_UBREAK;
      best_any = 1'b1;
    end
    for (int i = 0; i < N_EXT; i++) begin
      if (irq_i.ext_req[i] && (!best_any || {1'b0, irq_i.ext_lvl[i]} > best_lvl)) begin
        best_lvl = {1'b0, irq_i.ext_lvl[i]};
        best_vec = `CES_VEC_EXT_BASE + 8'(i);
        best_any = 1'b1;
      end
    end
    if (irq_i.per_req && (!best_any || {1'b0, irq_i.per_lvl} > best_lvl)) begin
      best_lvl = {1'b0, irq_i.per_lvl};
      best_vec = irq_i.per_vec;
      best_any = 1'b1;
    end
  end

  // Only the nonmaskable source bypasses the mask comparison.
  assign int_take = best_any && (best_nmi || best_lvl > {1'b0, mask});

  // Entry sequencer: choose a cause, push status, push pc, fetch vector.
  always_comb begin
    state_d   = state_q;
    mem_d     = mem_q;
    sp_d      = sp_q;
    pc_save_d = pc_save_q;
    sr_new_d  = sr_new_q;
    pc_new_d  = pc_new_q;
    vec_d     = vec_q;
    load_d    = 1'b0;
    ack_d     = 1'b0;
    // A new error from the other master in the clearing cycle stays pending.
    aerr_d    = aerr_q | {dma_err, cpu_err};
    unique case (state_q)
      CES_IDLE: begin
        if ((aerr_q != 2'h0 || cpu_err || dma_err) && insn_done_i) begin
          vec_d     = (aerr_q[0] || cpu_err) ? `CES_VEC_CPU_ADDR_ERR
                                             : `CES_VEC_DMA_ADDR_ERR;
          pc_save_d = next_pc_i;
          sr_new_d  = status_register_i;
          aerr_d    = (aerr_q[0] || cpu_err) ? {aerr_d[1], 1'b0} : 2'h0;
          state_d   = CES_PUSH_SR;
        end else if (slot_ill) begin
          vec_d     = `CES_VEC_SLOT_ILLEGAL;
          pc_save_d = br_target_i;
          sr_new_d  = status_register_i;
          state_d   = CES_PUSH_SR;
        end else if (undef_i) begin
          vec_d     = `CES_VEC_GEN_ILLEGAL;
          pc_save_d = cur_pc_i;
          sr_new_d  = status_register_i;
          state_d   = CES_PUSH_SR;
        end else if (trap_i) begin
          vec_d     = trap_vec_i;
          pc_save_d = next_pc_i;
          sr_new_d  = status_register_i;
          state_d   = CES_PUSH_SR;
        end else if (int_take && insn_done_i) begin
          vec_d     = best_vec;
          pc_save_d = next_pc_i;
          sr_new_d  = status_register_i;
          sr_new_d[`CES_SR_MASK_LSB +: 4] = best_nmi ? `CES_MASK_NMI
                                                     : best_lvl[3:0];
          ack_d     = 1'b1;
          state_d   = CES_PUSH_SR;
        end
        if (state_d == CES_PUSH_SR) begin
          // Stacked status is the value before the mask update.
          sp_d  = sp_i - `CES_STACK_STEP;
          mem_d = '{req: 1'b1, we: 1'b1, addr: sp_i - `CES_STACK_STEP,
                    wdata: status_register_i};
        end
      end
      CES_PUSH_SR: begin
        if (mem_ack_i) begin
          sp_d    = sp_q - `CES_STACK_STEP;
          mem_d   = '{req: 1'b1, we: 1'b1, addr: sp_q - `CES_STACK_STEP,
                      wdata: pc_save_q};
          state_d = CES_PUSH_PC;
        end
      end
      CES_PUSH_PC: begin
        if (mem_ack_i) begin
          mem_d   = '{req: 1'b1, we: 1'b0,
                      addr: vector_base_i + {22'h0, vec_q, 2'h0},
                      wdata: 32'h0000_0000};
          state_d = CES_FETCH;
        end
      end
      CES_FETCH: begin
        if (mem_ack_i) begin
          // The jump is taken directly, with no delay slot.
          pc_new_d = mem_rdata_i;
          mem_d    = '{req: 1'b0, we: 1'b0, addr: 32'h0, wdata: 32'h0};
          load_d   = 1'b1;
          state_d  = CES_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= CES_IDLE;
      mem_q     <= '{req: 1'b0, we: 1'b0, addr: 32'h0, wdata: 32'h0};
      sp_q      <= 32'h0000_0000;
      pc_save_q <= 32'h0000_0000;
      sr_new_q  <= 32'h0000_0000;
      pc_new_q  <= 32'h0000_0000;
      vec_q     <= 8'h00;
      aerr_q    <= 2'h0;
      load_q    <= 1'b0;
      ack_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      mem_q     <= mem_d;
      sp_q      <= sp_d;
      pc_save_q <= pc_save_d;
      sr_new_q  <= sr_new_d;
      pc_new_q  <= pc_new_d;
      vec_q     <= vec_d;
      aerr_q    <= aerr_d;
      load_q    <= load_d;
      ack_q     <= ack_d;
    end
  end

  assign mem_o             = mem_q;
  assign busy_o            = state_q != CES_IDLE;
  assign load_o            = load_q;
  assign program_counter_o = pc_new_q;
  assign sp_o              = sp_q;
  assign status_register_o = sr_new_q;
  assign int_ack_o         = ack_q;
  assign int_vec_o         = vec_q;

  // Checks on the design's own behaviour.
  a_fetch_odd: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_acc_i.valid && cpu_acc_i.fetch && cpu_acc_i.addr[0] |-> cpu_abort_o)
    else $error("odd fetch not flagged");
  a_fetch_periph: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_acc_i.valid && cpu_acc_i.fetch && ((cpu_acc_i.addr & PERIPH_MASK) == PERIPH_BASE)
    |-> cpu_abort_o)
    else $error("peripheral fetch not flagged");
  a_single_ext: assert property (@(posedge clk_i) disable iff (rst_i)
    dma_acc_i.valid && single_chip_i && ((dma_acc_i.addr & EXT_MASK) == EXT_BASE)
    |-> dma_abort_o)
    else $error("external access in single chip not flagged");
  a_word_align: assert property (@(posedge clk_i) disable iff (rst_i)
    dma_acc_i.valid && !dma_acc_i.fetch && !single_chip_i && dma_acc_i.addr[0] == 1'b0
    && dma_acc_i.size == CES_SZ_WORD |-> !dma_abort_o)
    else $error("even word access flagged");
  a_aerr_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == CES_IDLE && !insn_done_i && !slot_ill && !undef_i && !trap_i
    |=> state_q == CES_IDLE)
    else $error("entry before instruction completed");
  a_push_order: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == CES_IDLE ##1 state_q == CES_PUSH_SR |->
    mem_o.we && mem_o.addr == $past(sp_i) - 32'h4 && mem_o.wdata == $past(status_register_i))
    else $error("status push wrong");
  a_mask_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    int_ack_o |-> $past(irq_i.nmi) || status_register_o[`CES_SR_MASK_LSB +: 4] > $past(mask))
    else $error("interrupt taken at or below mask");
  a_nmi_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    int_ack_o && vec_q == `CES_VEC_NMI |-> status_register_o[`CES_SR_MASK_LSB +: 4] == 4'hF)
    else $error("nmi mask not all ones");
  a_vec_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == CES_FETCH |-> mem_o.addr == vector_base_i + {22'h0, vec_q, 2'h0} && !mem_o.we)
    else $error("vector address wrong");
  a_entry_done: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == CES_FETCH && mem_ack_i |=> load_o && state_q == CES_IDLE)
    else $error("no jump after vector fetch");

  c_addr_err: cover property (@(posedge clk_i) disable iff (rst_i)
    load_o && vec_q == `CES_VEC_CPU_ADDR_ERR);
  c_nmi: cover property (@(posedge clk_i) disable iff (rst_i)
    int_ack_o && vec_q == `CES_VEC_NMI);
  c_slot: cover property (@(posedge clk_i) disable iff (rst_i)
    load_o && vec_q == `CES_VEC_SLOT_ILLEGAL);
  c_trap: cover property (@(posedge clk_i) disable iff (rst_i) trap_i && !busy_o);

endmodule : ces_sequencer

// ==== design/ces_defs.svh ====
// Constants for the exception sequencer: vectors, field positions, defaults.
`ifndef CES_DEFS_SVH
`define CES_DEFS_SVH

// Vector numbers of the fixed exception sources.
`define CES_VEC_GEN_ILLEGAL 8'h04
`define CES_VEC_SLOT_ILLEGAL 8'h06
`define CES_VEC_CPU_ADDR_ERR 8'h09
`define CES_VEC_DMA_ADDR_ERR 8'h0A
`define CES_VEC_NMI 8'h0B
`define CES_VEC_UBREAK 8'h0C
`define CES_VEC_EXT_BASE 8'h40

// Fixed priority levels.
`define CES_LVL_NMI 5'h10
`define CES_LVL_UBREAK 5'h0F
`define CES_MASK_NMI 4'hF

// Mask field position inside the status register.
`define CES_SR_MASK_LSB 4

// Each stack push moves the stack pointer by one long (four bytes).
`define CES_STACK_STEP 32'h0000_0004

// Default address windows (plain defaults, overridable by parameter).
`define CES_PERIPH_BASE 32'hFFFF_8000
`define CES_PERIPH_MASK 32'hFFFF_8000
`define CES_PER8_BASE 32'hFFFF_8000
`define CES_PER8_MASK 32'hFFFF_C000
`define CES_EXT_BASE 32'h0040_0000
`define CES_EXT_MASK 32'hF040_0000

`endif

// ==== design/ces_pkg.sv ====
// Types shared by the exception sequencer and its address checker.
package ces_pkg;

  // Access size of a bus cycle.
  typedef enum logic [1:0] {
    CES_SZ_BYTE = 2'h0,
    CES_SZ_WORD = 2'h1,
    CES_SZ_LONG = 2'h2
  } ces_size_e;

  // One bus access offered for checking.
  typedef struct packed {
    logic        valid;
    logic        fetch;
    ces_size_e   size;
    logic [31:0] addr;
  } ces_acc_s;

  // Interrupt requests as seen from the interrupt controller.
  typedef struct packed {
    logic            nmi;
    logic            ubreak;
    logic [7:0]      ext_req;
    logic [7:0][3:0] ext_lvl;
    logic            per_req;
    logic [3:0]      per_lvl;
    logic [7:0]      per_vec;
  } ces_irq_s;

  // Memory request used for stacking and vector fetch.
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ces_mem_s;

  // Entry sequence states, Gray coded around the loop.
  typedef enum logic [1:0] {
    CES_IDLE    = 2'h0,
    CES_PUSH_SR = 2'h1,
    CES_PUSH_PC = 2'h3,
    CES_FETCH   = 2'h2
  } ces_state_e;

endpackage : ces_pkg

// ==== design/ces_addr_check.sv ====
// Address error check for one bus master's access.
`timescale 1ns/1ns
`include "ces_defs.svh"
module ces_addr_check #(
  parameter logic [31:0] PERIPH_BASE = `CES_PERIPH_BASE,
  parameter logic [31:0] PERIPH_MASK = `CES_PERIPH_MASK,
  parameter logic [31:0] PER8_BASE   = `CES_PER8_BASE,
  parameter logic [31:0] PER8_MASK   = `CES_PER8_MASK,
  parameter logic [31:0] EXT_BASE    = `CES_EXT_BASE,
  parameter logic [31:0] EXT_MASK    = `CES_EXT_MASK
) (
  input  wire ces_pkg::ces_acc_s acc_i,         // Access under check.
  input  wire logic              single_chip_i, // Single chip mode strap.
  output logic                   err_o          // Access is an address error.
);
  import ces_pkg::*;

  logic in_periph;
  logic in_per8;
  logic in_ext;
  logic fetch_err;
  logic data_err;

  // Space decode by base and mask; the 8-bit window lies inside peripheral space.
  assign in_periph = (acc_i.addr & PERIPH_MASK) == PERIPH_BASE;
  assign in_per8   = in_periph && ((acc_i.addr & PER8_MASK) == PER8_BASE);
  assign in_ext    = (acc_i.addr & EXT_MASK) == EXT_BASE;

  // Fetches must be even, outside peripheral space and on-chip when single chip.
  assign fetch_err = acc_i.addr[0]
                  || in_periph
                  || (single_chip_i && in_ext);

  // Data alignment, narrow peripheral and single chip checks.
  assign data_err = ((acc_i.size == CES_SZ_WORD) && acc_i.addr[0])
                 || ((acc_i.size == CES_SZ_LONG) && (acc_i.addr[1:0] != 2'h0))
                 || ((acc_i.size == CES_SZ_LONG) && in_per8)
                 || (single_chip_i && in_ext);

  assign err_o = acc_i.valid && (acc_i.fetch ? fetch_err : data_err);

endmodule : ces_addr_check

// ==== bench/ces_mem_model.sv ====
// Memory partner that answers stack writes and vector reads.
`timescale 1ns/1ns
module ces_mem_model (
  input  wire ces_pkg::ces_mem_s mem_i,   // Request from the sequencer.
  input  wire logic              clk_i,   // Core clock.
  input  wire logic              rst_i,   // Reset, active high.
  input  wire logic [3:0]        wait_i,  // Idle cycles before each answer.
  output logic                   ack_o,   // Cycle done, one cycle.
  output logic [31:0]            rdata_o  // Read data, valid with ack_o.
);
  import ces_pkg::*;
  logic [3:0] cnt_q;
  // Outside an answer the data toggles every cycle, so a stale read never looks right.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      cnt_q   <= 4'h0;
      rdata_o <= 32'h0;
    end else begin
      rdata_o <= ~rdata_o;
      ack_o   <= 1'b0;
      if (mem_i.req && !ack_o) begin
        if (cnt_q == wait_i) begin
          ack_o   <= 1'b1;
          cnt_q   <= 4'h0;
          rdata_o <= mem_i.addr ^ 32'h5A00_0000;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : ces_mem_model

// ==== bench/ces_sequencer_tb.sv ====
// Self-checking bench for the exception sequencer.
`timescale 1ns/1ns
module ces_sequencer_tb;
  import ces_pkg::*;
  logic clk_i, rst_i, single_chip_i, cpu_abort_o, dma_abort_o, int_ack_o, insn_done_i, trap_i;
  logic undef_i, in_slot_i, pc_write_i, mem_ack_i, busy_o, load_o;
  logic [7:0] int_vec_o, trap_vec_i;
  logic [31:0] cur_pc_i, next_pc_i, br_target_i, status_register_i, sp_i, vector_base_i;
  logic [31:0] mem_rdata_i, program_counter_o, sp_o, status_register_o;
  logic [3:0] wait_w;
  ces_acc_s cpu_acc_i, dma_acc_i;
  ces_irq_s irq_i;
  ces_mem_s mem_o;
  int fail_count, comparisons, cycles, ack_cnt;

  ces_sequencer ces_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .single_chip_i(single_chip_i),
    .cpu_acc_i(cpu_acc_i), .dma_acc_i(dma_acc_i), .cpu_abort_o(cpu_abort_o),
    .dma_abort_o(dma_abort_o), .irq_i(irq_i), .int_ack_o(int_ack_o), .int_vec_o(int_vec_o),
    .insn_done_i(insn_done_i), .trap_i(trap_i), .trap_vec_i(trap_vec_i), .undef_i(undef_i),
    .in_slot_i(in_slot_i), .pc_write_i(pc_write_i), .cur_pc_i(cur_pc_i), .next_pc_i(next_pc_i),
    .br_target_i(br_target_i), .status_register_i(status_register_i), .sp_i(sp_i),
    .vector_base_i(vector_base_i), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .load_o(load_o),
    .program_counter_o(program_counter_o), .sp_o(sp_o), .status_register_o(status_register_o));
  ces_mem_model ces_mem_model_inst (.mem_i(mem_o), .clk_i(clk_i), .rst_i(rst_i),
    .wait_i(wait_w), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // Clock and a cycle ceiling; a hang counts as a mismatch.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (int_ack_o === 1'b1) ack_cnt++;
    if (cycles == 4000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Offer one access to the CPU port, and data accesses to the DMA port as well.
  task automatic acc(input logic f, input ces_size_e sz, input logic [31:0] a,
                     input logic sc, input logic e);
    @(posedge clk_i);
    cpu_acc_i     <= '{1'b1, f, sz, a};
    dma_acc_i     <= f ? ces_acc_s'('0) : ces_acc_s'{1'b1, 1'b0, sz, a};
    single_chip_i <= sc;
    @(negedge clk_i);
    chk(32'(cpu_abort_o), 32'(e));
    if (!f) chk(32'(dma_abort_o), 32'(e));
  endtask : acc

  // Follow one entry: two pushes, a vector read, then the load pulse.
  task automatic entry(input logic [7:0] vec, input logic [31:0] pc, input logic [31:0] sr_o,
                       input logic intr);
    logic [31:0] sr_in, va;
    int n;
    sr_in = status_register_i;
    va = vector_base_i + {22'h0, vec, 2'h0};
    ack_cnt = 0;
    n = 0;
    while (busy_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    chk(32'(busy_o), 32'h1);
    @(posedge clk_i);
    {trap_i, undef_i, in_slot_i, pc_write_i, insn_done_i} <= 5'h0;
    irq_i <= '0;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (!(mem_o.req === 1'b1 && mem_ack_i === 1'b1) && n < 20) begin
        @(negedge clk_i);
        n++;
      end
      chk(mem_o.addr, k == 0 ? sp_i - 32'h4 : k == 1 ? sp_i - 32'h8 : va);
      chk(32'(mem_o.we), 32'(k < 2));
      if (k < 2) chk(mem_o.wdata, k == 0 ? sr_in : pc);
      @(negedge clk_i);
    end
    n = 0;
    while (load_o !== 1'b1 && n < 10) begin
      @(negedge clk_i);
      n++;
    end
    chk(program_counter_o, va ^ 32'h5A00_0000);
    chk(sp_o, sp_i - 32'h8);
    chk(status_register_o, sr_o);
    chk(32'(ack_cnt), 32'(intr));
    if (intr) chk(32'(int_vec_o), 32'(vec));
  endtask : entry

  task automatic t_addr();
    acc(1'b1, CES_SZ_WORD, 32'h0000_1000, 1'b0, 1'b0);
    acc(1'b1, CES_SZ_WORD, 32'h0000_1001, 1'b0, 1'b1);
    acc(1'b1, CES_SZ_WORD, 32'hFFFF_C000, 1'b0, 1'b1);
    acc(1'b1, CES_SZ_WORD, 32'h0040_0000, 1'b0, 1'b0);
    acc(1'b1, CES_SZ_WORD, 32'h0040_0000, 1'b1, 1'b1);
    acc(1'b0, CES_SZ_WORD, 32'h0000_1002, 1'b0, 1'b0);
    acc(1'b0, CES_SZ_WORD, 32'h0000_1003, 1'b0, 1'b1);
    acc(1'b0, CES_SZ_LONG, 32'h0000_1004, 1'b0, 1'b0);
    acc(1'b0, CES_SZ_LONG, 32'h0000_1006, 1'b0, 1'b1);
    acc(1'b0, CES_SZ_BYTE, 32'hFFFF_8001, 1'b0, 1'b0);
    acc(1'b0, CES_SZ_LONG, 32'hFFFF_C004, 1'b0, 1'b0);
    acc(1'b0, CES_SZ_LONG, 32'hFFFF_8004, 1'b0, 1'b1);
    acc(1'b0, CES_SZ_BYTE, 32'h0040_0001, 1'b1, 1'b1);
    @(posedge clk_i);
    cpu_acc_i     <= '0;
    dma_acc_i     <= '0;
    single_chip_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk(32'(busy_o), 32'h0);
    @(posedge clk_i);
    insn_done_i <= 1'b1;
    entry(8'h09, next_pc_i, status_register_i, 1'b0);
    @(posedge clk_i);
    insn_done_i <= 1'b1;
    entry(8'h0A, next_pc_i, status_register_i, 1'b0);
    $display("address error test done");
  endtask : t_addr

  // Trap, general illegal, slot illegal by undefined code and by a pc write.
  task automatic t_instr();
    wait_w = 4'h2;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      trap_i     <= (k == 0);
      undef_i    <= (k == 1) || (k == 2);
      in_slot_i  <= (k >= 2);
      pc_write_i <= (k == 3);
      entry(k == 0 ? 8'h3F : k == 1 ? 8'h04 : 8'h06,
            k == 0 ? next_pc_i : k == 1 ? cur_pc_i : br_target_i,
            status_register_i, 1'b0);
    end
    wait_w = 4'h0;
    $display("instruction test done");
  endtask : t_instr

  function automatic ces_irq_s mk(input int n, input int u, input logic [7:0] r,
                                  input logic [31:0] l, input int p, input logic [3:0] pl);
    return '{1'(n), 1'(u), r, l, 1'(p), pl, 8'h50};
  endfunction : mk

  task automatic irq(input ces_irq_s q, input logic [3:0] m, input int ok,
                     input logic [7:0] vec, input logic [3:0] nm);
    @(posedge clk_i);
    status_register_i <= {24'h3, m, 4'h1};
    irq_i             <= q;
    insn_done_i       <= 1'b1;
    @(negedge clk_i);
    if (ok != 0) begin
      entry(vec, next_pc_i, {24'h3, nm, 4'h1}, 1'b1);
    end else begin
      repeat (8) @(negedge clk_i);
      chk(32'(busy_o), 32'h0);
      @(posedge clk_i);
      irq_i       <= '0;
      insn_done_i <= 1'b0;
    end
  endtask : irq

  task automatic t_irq();
    irq(mk(0, 0, 8'h08, 32'h0000_5000, 0, 4'h0), 4'h4, 1, 8'h43, 4'h5);
    irq(mk(0, 0, 8'h08, 32'h0000_5000, 0, 4'h0), 4'h5, 0, 8'h00, 4'h0);
    irq(mk(0, 0, 8'h81, 32'h9000_0003, 1, 4'h8), 4'h0, 1, 8'h47, 4'h9);
    irq(mk(0, 0, 8'h81, 32'h9000_0003, 1, 4'hC), 4'h0, 1, 8'h50, 4'hC);
    irq(mk(0, 1, 8'h81, 32'h9000_0003, 1, 4'hC), 4'h0, 1, 8'h0C, 4'hF);
    irq(mk(0, 1, 8'h81, 32'h9000_0003, 1, 4'hC), 4'hF, 0, 8'h00, 4'h0);
    irq(mk(1, 1, 8'h81, 32'h9000_0003, 1, 4'hC), 4'hF, 1, 8'h0B, 4'hF);
    $display("interrupt test done");
  endtask : t_irq

  // Inputs get values at time zero; reset is held for two cycles.
  initial begin
    {rst_i, single_chip_i, insn_done_i, trap_i, undef_i, in_slot_i, pc_write_i} = 7'h40;
    {cpu_acc_i, dma_acc_i, irq_i} = '0;
    {fail_count, comparisons, cycles, ack_cnt} = '0;
    wait_w = 4'h0;
    trap_vec_i = 8'h3F;
    cur_pc_i = 32'h0000_0100;
    next_pc_i = 32'h0000_0102;
    br_target_i = 32'h0000_0300;
    status_register_i = 32'h0000_03F1;
    sp_i = 32'h0000_2000;
    vector_base_i = 32'h0000_4000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_addr();
    t_instr();
    t_irq();
    stop_test();
  end
endmodule : ces_sequencer_tb
